// File: logic_unit_pkg.sv
// Constants, operation codes and decode helpers of the integer logical unit.
// Summary of operation
// RL1 - Bitwise on 32 bits; immediates zero-extended or shifted.
// RL2 - Record bit set updates condition field zero.
// RL3 - Exception register is never modified.
// RL4 - Destination register receives result; sources named separately.
// RL5 - AND of both sources, both forms.
// RL6 - AND with zero-extended immediate, always records.
// RL7 - AND with immediate in upper halfword, records.
// RL8 - AND with inverted second source, both forms.
// RL9 - Inverted AND of sources, both forms.
// RL10 - Inverted OR of sources, both forms.
// RL11 - OR of both sources, both forms.
// RL12 - OR with zero-extended immediate, never records.
// RL13 - OR with upper-halfword immediate, never records.
// RL14 - OR with inverted second source, both forms.
// RL15 - Inverted XOR of sources, both forms.
// RL16 - XOR of both sources, both forms.
// RL17 - XOR with zero-extended immediate, never records.
// RL18 - XOR with upper-halfword immediate, never records.
// RL19 - Sign-extend low byte, optional record.
// RL20 - Sign-extend low halfword, optional record.
// RL21 - Record: signed compare with zero, copy overflow.
package logic_unit_pkg;

   // ==========================================================
   // Widths and sizes
   localparam int unsigned WORD_W = 32;
   localparam int unsigned IMM_W = 16;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned HALF_W = 16;
   localparam int unsigned GPR_COUNT = 32;
   localparam int unsigned GPR_IDX_W = 5;
   localparam int unsigned CR_FIELD_W = 4;

   // ==========================================================
   // Field positions
   // Condition field packing: [3] less, [2] greater, [1] equal, [0] summary overflow.
   localparam int unsigned CR_LT_BIT = 3;
   localparam int unsigned CR_GT_BIT = 2;
   localparam int unsigned CR_EQ_BIT = 1;
   localparam int unsigned CR_SO_BIT = 0;
   // Summary overflow is the most significant bit of the exception register.
   localparam int unsigned XER_SO_BIT = 31;

   // ==========================================================
   // Reset values and timing
   localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
   localparam logic [CR_FIELD_W-1:0] CR_RESET = 4'h0;
   localparam int unsigned ISSUE_TO_RETIRE_CYCLES = 2;

   // ==========================================================
   // Operations
   typedef enum logic [3:0] {
      op_and,
      op_and_with_not,
      op_not_and,
      op_not_or,
      op_or,
      op_or_with_not,
      op_xnor_equivalence,
      op_xor,
      op_and_imm_rec,
      op_and_imm_shift_rec,
      op_or_imm,
      op_or_imm_shift,
      op_xor_imm,
      op_xor_imm_shift,
      op_sign_extend_byte,
      op_sign_extend_half
   } op_t;

   // Whether the condition field is written, given the operation and its record bit.
   function automatic logic record_effective(input op_t op, input logic rec);
      logic r;
      r = rec;
      case (op)
         op_and_imm_rec, op_and_imm_shift_rec: r = 1'b1;
         op_or_imm, op_or_imm_shift, op_xor_imm, op_xor_imm_shift: r = 1'b0;
         default: r = rec;
      endcase
      return r;
   endfunction

endpackage

// File: logic_op_if.sv
// Interface carrying one operation and its result between the unit and its evaluator.
`timescale 1ns/1ps
`default_nettype none
interface logic_op_if;
   import logic_unit_pkg::*;
   op_t op;
   logic [WORD_W-1:0] src_s;
   logic [WORD_W-1:0] src_b;
   logic [IMM_W-1:0] imm;
   logic [WORD_W-1:0] result;
   logic lt;
   logic gt;
   logic eq;

   modport issue (output op, output src_s, output src_b, output imm,
                  input result, input lt, input gt, input eq);
   modport exec (input op, input src_s, input src_b, input imm,
                 output result, output lt, output gt, output eq);
endinterface
`default_nettype wire

// File: gpr_file.sv
// General purpose register file with two write ports and registered, forwarding reads.
`timescale 1ns/1ps
`default_nettype none
module gpr_file
   import logic_unit_pkg::*;
#(
   parameter int unsigned DEPTH = GPR_COUNT,
   parameter int unsigned WIDTH = WORD_W
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wa_en,
   input wire logic [GPR_IDX_W-1:0] wa_idx,
   input wire logic [WIDTH-1:0] wa_data,
   input wire logic wb_en,
   input wire logic [GPR_IDX_W-1:0] wb_idx,
   input wire logic [WIDTH-1:0] wb_data,
   input wire logic [GPR_IDX_W-1:0] ra_idx,
   input wire logic [GPR_IDX_W-1:0] rb_idx,
   output logic [WIDTH-1:0] ra_data_q,
   output logic [WIDTH-1:0] rb_data_q
);

   logic [WIDTH-1:0] words_q [DEPTH];

   // ==========================================================
   // Elaboration checks
   if (DEPTH < 1 || DEPTH > (1 << GPR_IDX_W)) begin : g_bad_depth
      $error("DEPTH must lie between 1 and the index range");
   end
   if (WIDTH < 1) begin : g_bad_width
      $error("WIDTH must be at least one bit");
   end

   // ==========================================================
   // Storage: port a wins when both ports hit the same word.
   for (genvar i = 0; i < DEPTH; i++) begin : g_word
      wire logic hit_a = wa_en && (wa_idx == GPR_IDX_W'(i));
      wire logic hit_b = wb_en && (wb_idx == GPR_IDX_W'(i));
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            words_q[i] <= WIDTH'(WORD_RESET);
         end else if (hit_a || hit_b) begin
            words_q[i] <= hit_a ? wa_data : wb_data;
         end
      end
   end

   // ==========================================================
   // Reads see a write of the same edge, so back-to-back dependent operations need no stall.
   // Every write-port signal is an argument, so the assignments follow any of them as it moves.
   function automatic logic [WIDTH-1:0] read_word(input logic [GPR_IDX_W-1:0] idx,
                                                  input logic [WIDTH-1:0] stored,
                                                  input logic a_en,
                                                  input logic [GPR_IDX_W-1:0] a_idx,
                                                  input logic [WIDTH-1:0] a_data,
                                                  input logic b_en,
                                                  input logic [GPR_IDX_W-1:0] b_idx,
                                                  input logic [WIDTH-1:0] b_data);
      logic [WIDTH-1:0] v;
      v = stored;
      if (a_en && a_idx == idx) begin
         v = a_data;
      end else if (b_en && b_idx == idx) begin
         v = b_data;
      end
      return v;
   endfunction

   wire logic [WIDTH-1:0] ra_d = read_word(ra_idx, words_q[ra_idx], wa_en, wa_idx, wa_data, wb_en, wb_idx, wb_data);
   wire logic [WIDTH-1:0] rb_d = read_word(rb_idx, words_q[rb_idx], wa_en, wa_idx, wa_data, wb_en, wb_idx, wb_data);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ra_data_q <= WIDTH'(WORD_RESET);
         rb_data_q <= WIDTH'(WORD_RESET);
      end else begin
         ra_data_q <= ra_d;
         rb_data_q <= rb_d;
      end
   end

endmodule
`default_nettype wire

// File: logic_eval.sv
// Combinational evaluator of the bitwise and sign-extension operations.
`timescale 1ns/1ps
`default_nettype none
module logic_eval
   import logic_unit_pkg::*;
(
   logic_op_if.exec bus
);

   // ==========================================================
   // Immediate forms
   wire logic [WORD_W-1:0] imm_zext = {{(WORD_W-IMM_W){1'b0}}, bus.imm}; // RL1
   wire logic [WORD_W-1:0] imm_shift = {bus.imm, {(WORD_W-IMM_W){1'b0}}}; // RL1
   wire logic [WORD_W-1:0] s = bus.src_s;
   wire logic [WORD_W-1:0] b = bus.src_b;
   wire logic [WORD_W-1:0] ext_byte = {{(WORD_W-BYTE_W){s[BYTE_W-1]}}, s[BYTE_W-1:0]};
   wire logic [WORD_W-1:0] ext_half = {{(WORD_W-HALF_W){s[HALF_W-1]}}, s[HALF_W-1:0]};

   logic [WORD_W-1:0] res;

   // ==========================================================
   // Operation select
   always_comb begin
      case (bus.op)
         op_and: res = s & b; // RL5
         op_and_with_not: res = s & ~b; // RL8
         op_not_and: res = ~(s & b); // RL9
         op_not_or: res = ~(s | b); // RL10
         op_or: res = s | b; // RL11
         op_or_with_not: res = s | ~b; // RL14
         op_xnor_equivalence: res = ~(s ^ b); // RL15
         op_xor: res = s ^ b; // RL16
         op_and_imm_rec: res = s & imm_zext; // RL6
         op_and_imm_shift_rec: res = s & imm_shift; // RL7
         op_or_imm: res = s | imm_zext; // RL12
         op_or_imm_shift: res = s | imm_shift; // RL13
         op_xor_imm: res = s ^ imm_zext; // RL17
         op_xor_imm_shift: res = s ^ imm_shift; // RL18
         op_sign_extend_byte: res = ext_byte; // RL19
         op_sign_extend_half: res = ext_half; // RL20
         default: res = WORD_RESET;
      endcase
   end

   // ==========================================================
   // Signed comparison of the result with zero
   assign bus.result = res;
   assign bus.lt = res[WORD_W-1]; // RL21
   assign bus.eq = (res == WORD_RESET); // RL21
   assign bus.gt = !res[WORD_W-1] && (res != WORD_RESET); // RL21

endmodule
`default_nettype wire

// File: integer_logical_unit.sv
// Integer logical and sign-extension unit: issue, operand read, evaluation and retire.
`timescale 1ns/1ps
`default_nettype none
module integer_logical_unit
   import logic_unit_pkg::*;
#(
   parameter int unsigned GPRS = GPR_COUNT
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic issue_valid,
   input wire op_t issue_op,
   input wire logic record_bit,
   input wire logic [GPR_IDX_W-1:0] dest_reg,
   input wire logic [GPR_IDX_W-1:0] src_reg_s,
   input wire logic [GPR_IDX_W-1:0] src_reg_b,
   input wire logic [IMM_W-1:0] unsigned_imm,
   input wire logic [WORD_W-1:0] fixed_point_exception_reg,
   input wire logic load_valid,
   input wire logic [GPR_IDX_W-1:0] load_index,
   input wire logic [WORD_W-1:0] load_data,
   output logic retire_valid_q,
   output logic [GPR_IDX_W-1:0] retire_dest_q,
   output logic [WORD_W-1:0] retire_result_q,
   output logic cond_update_q,
   output logic [CR_FIELD_W-1:0] cond_field_zero_q
);

   // ==========================================================
   // Elaboration checks
   if (GPRS < 2 || GPRS > (1 << GPR_IDX_W)) begin : g_bad_depth
      $error("GPRS must lie between 2 and the index range");
   end
   if (WORD_W != 2 * IMM_W) begin : g_bad_width
      $error("Word width must be twice the immediate width");
   end

   // ==========================================================
   // Execute stage registers, one cycle after issue
   logic s1_valid_q;
   op_t s1_op_q;
   logic s1_rec_q;
   logic [GPR_IDX_W-1:0] s1_dest_q;
   logic [IMM_W-1:0] s1_imm_q;
   logic [WORD_W-1:0] rd_s;
   logic [WORD_W-1:0] rd_b;

   wire logic issue_rec = record_effective(issue_op, record_bit); // RL2

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1_valid_q <= 1'b0;
         s1_op_q <= op_and;
         s1_rec_q <= 1'b0;
         s1_dest_q <= '0;
         s1_imm_q <= '0;
      end else begin
         s1_valid_q <= issue_valid;
         s1_op_q <= issue_op;
         s1_rec_q <= issue_valid && issue_rec;
         s1_dest_q <= dest_reg; // RL4
         s1_imm_q <= unsigned_imm;
      end
   end

   // ==========================================================
   // Evaluation
   logic_op_if op_bus ();

   assign op_bus.op = s1_op_q;
   assign op_bus.src_s = rd_s;
   assign op_bus.src_b = rd_b;
   assign op_bus.imm = s1_imm_q;

   logic_eval u_eval (
      .bus(op_bus.exec)
   );

   // The exception register is only looked at; the unit has no path that could write it.
   wire logic so_copy = fixed_point_exception_reg[XER_SO_BIT]; // RL3

   wire logic [CR_FIELD_W-1:0] cond_new = {op_bus.lt, op_bus.gt, op_bus.eq, so_copy}; // RL21

   // ==========================================================
   // Register file: the retiring result is written on port a, the core's load port on b.
   gpr_file #(
      .DEPTH(GPRS),
      .WIDTH(WORD_W)
   ) u_gprs (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wa_en(s1_valid_q),
      .wa_idx(s1_dest_q), // RL4
      .wa_data(op_bus.result),
      .wb_en(load_valid),
      .wb_idx(load_index),
      .wb_data(load_data),
      .ra_idx(src_reg_s), // RL4
      .rb_idx(src_reg_b), // RL4
      .ra_data_q(rd_s),
      .rb_data_q(rd_b)
   );

   // ==========================================================
   // Retire and condition field
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         retire_valid_q <= 1'b0;
         retire_dest_q <= '0;
         retire_result_q <= WORD_RESET;
         cond_update_q <= 1'b0;
      end else begin
         retire_valid_q <= s1_valid_q;
         retire_dest_q <= s1_dest_q;
         retire_result_q <= op_bus.result;
         cond_update_q <= s1_rec_q; // RL2
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cond_field_zero_q <= CR_RESET;
      end else if (s1_rec_q) begin
         cond_field_zero_q <= cond_new; // RL2
      end
   end

endmodule
`default_nettype wire

// File: integer_logical_unit_asserts.sv
// Port-level concurrent checks of the integer logical unit.
`timescale 1ns/1ps
`default_nettype none
module integer_logical_unit_asserts
   import logic_unit_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic issue_valid,
   input wire op_t issue_op,
   input wire logic record_bit,
   input wire logic [GPR_IDX_W-1:0] dest_reg,
   input wire logic [WORD_W-1:0] fixed_point_exception_reg,
   input wire logic retire_valid_q,
   input wire logic [GPR_IDX_W-1:0] retire_dest_q,
   input wire logic [WORD_W-1:0] retire_result_q,
   input wire logic cond_update_q,
   input wire logic [CR_FIELD_W-1:0] cond_field_zero_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Issue kinds
   sequence s_forced;
      issue_valid && issue_op inside {op_and_imm_rec, op_and_imm_shift_rec};
   endsequence
   sequence s_barred;
      issue_valid && issue_op inside {op_or_imm, op_or_imm_shift, op_xor_imm, op_xor_imm_shift};
   endsequence
   sequence s_free;
      issue_valid && (issue_op < op_and_imm_rec || issue_op > op_xor_imm_shift);
   endsequence
   // ==========================================================
   // Checks
   AST_RETIRE_LAT: assert property (issue_valid |-> ##2 retire_valid_q)
      else $error("Retire pulse missing two cycles after issue.");
   AST_NO_EXTRA: assert property (retire_valid_q |-> $past(issue_valid, 2))
      else $error("Retire pulse without an issue.");
   AST_DEST: assert property (issue_valid |-> ##2 (retire_dest_q == $past(dest_reg, 2)))
      else $error("Retire index differs from issued destination.");
   AST_FORCED: assert property (s_forced |-> ##2 cond_update_q)
      else $error("Immediate AND did not record.");
   AST_BARRED: assert property (s_barred |-> ##2 !cond_update_q)
      else $error("Immediate OR or XOR recorded.");
   AST_REC: assert property (s_free |-> ##2 (cond_update_q == $past(record_bit, 2)))
      else $error("Condition update disagrees with record bit.");
   AST_HOLD: assert property (!cond_update_q |-> $stable(cond_field_zero_q))
      else $error("Condition field moved without an update.");
   AST_FLAGS: assert property (cond_update_q |-> cond_field_zero_q[3:1] ==
      {$signed(retire_result_q) < 0, $signed(retire_result_q) > 0, retire_result_q == 0})
      else $error("Condition flags do not match result sign.");
   AST_PAIR: assert property (cond_update_q |-> retire_valid_q)
      else $error("Condition update outside a retire.");
   AST_SO: assert property (cond_update_q |-> cond_field_zero_q[0] == $past(fixed_point_exception_reg[XER_SO_BIT]))
      else $error("Summary overflow copy in condition field is wrong.");
endmodule
bind integer_logical_unit integer_logical_unit_asserts u_chk (.clk_sys, .rst_n, .issue_valid, .issue_op,
   .record_bit, .dest_reg, .fixed_point_exception_reg, .retire_valid_q, .retire_dest_q, .retire_result_q,
   .cond_update_q, .cond_field_zero_q);
`default_nettype wire

// File: integer_logical_unit_test.sv
// Self-checking random bench of the integer logical unit.
`timescale 1ns/1ps
`default_nettype none
module integer_logical_unit_test;
   import logic_unit_pkg::*;
   typedef struct packed {logic v; logic rec; logic [4:0] d; logic [31:0] r;} exp_t;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic issue_valid = 1'b0;
   op_t issue_op = op_and;
   logic record_bit = 1'b0;
   logic [4:0] dest_reg = 5'h00;
   logic [4:0] src_reg_s = 5'h00;
   logic [4:0] src_reg_b = 5'h00;
   logic [15:0] unsigned_imm = 16'h0000;
   logic [31:0] fixed_point_exception_reg = 32'h0000_0000;
   logic load_valid = 1'b0;
   logic [4:0] load_index = 5'h00;
   logic [31:0] load_data = 32'h0000_0000;
   logic retire_valid_q;
   logic [4:0] retire_dest_q;
   logic [31:0] retire_result_q;
   logic cond_update_q;
   logic [3:0] cond_field_zero_q;
   logic [31:0] gpr [32];
   logic [31:0] seed = 32'h0000_005d;
   logic [31:0] r;
   logic [3:0] cond_exp = 4'h0;
   exp_t p1 = '0;
   exp_t p2 = '0;
   int n_fail = 0;
   int checks = 0;
   int cycles = 0;
   always #5 clk_sys = ~clk_sys;
   integer_logical_unit dut (.clk_sys(clk_sys), .rst_n(rst_n), .issue_valid(issue_valid), .issue_op(issue_op),
      .record_bit(record_bit), .dest_reg(dest_reg), .src_reg_s(src_reg_s), .src_reg_b(src_reg_b),
      .unsigned_imm(unsigned_imm), .fixed_point_exception_reg(fixed_point_exception_reg),
      .load_valid(load_valid), .load_index(load_index), .load_data(load_data),
      .retire_valid_q(retire_valid_q), .retire_dest_q(retire_dest_q), .retire_result_q(retire_result_q),
      .cond_update_q(cond_update_q), .cond_field_zero_q(cond_field_zero_q));
   // ==========================================================
   // Reference functions
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] calc(op_t op, logic [31:0] s, logic [31:0] b, logic [15:0] i);
      case (op)
         op_and: return s & b;
         op_and_with_not: return s & ~b;
         op_not_and: return ~(s & b);
         op_not_or: return ~(s | b);
         op_or: return s | b;
         op_or_with_not: return s | ~b;
         op_xnor_equivalence: return ~(s ^ b);
         op_xor: return s ^ b;
         op_and_imm_rec: return s & {16'h0000, i};
         op_and_imm_shift_rec: return s & {i, 16'h0000};
         op_or_imm: return s | {16'h0000, i};
         op_or_imm_shift: return s | {i, 16'h0000};
         op_xor_imm: return s ^ {16'h0000, i};
         op_xor_imm_shift: return s ^ {i, 16'h0000};
         op_sign_extend_byte: return {{24{s[7]}}, s[7:0]};
         default: return {{16{s[15]}}, s[15:0]};
      endcase
   endfunction
   function automatic logic rec_of(op_t op, logic rec);
      if (op inside {op_and_imm_rec, op_and_imm_shift_rec}) return 1'b1;
      if (op inside {op_or_imm, op_or_imm_shift, op_xor_imm, op_xor_imm_shift}) return 1'b0;
      return rec;
   endfunction
   // ==========================================================
   // Drivers and checks
   task automatic chk(string name, logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, e, g);
      end
   endtask
   // Checks the op issued two steps earlier, then offers a new one.
   task automatic step(logic v, op_t op, logic rec, logic [4:0] d, logic [4:0] s, logic [4:0] b, logic [15:0] i);
      @(negedge clk_sys);
      chk("retire_valid_q", {31'h0, p2.v}, {31'h0, retire_valid_q});
      chk("cond_update_q", {31'h0, p2.v & p2.rec}, {31'h0, cond_update_q});
      if (p2.v) begin
         chk("retire_dest_q", {27'h0, p2.d}, {27'h0, retire_dest_q});
         chk("retire_result_q", p2.r, retire_result_q);
      end
      if (p2.v & p2.rec) cond_exp = {$signed(p2.r) < 0, $signed(p2.r) > 0, p2.r == 0,
         fixed_point_exception_reg[31]};
      chk("cond_field_zero_q", {28'h0, cond_exp}, {28'h0, cond_field_zero_q});
      p2 = p1;
      p1 = {v, rec_of(op, rec), d, calc(op, gpr[s], gpr[b], i)};
      if (v) gpr[d] = p1.r;
      load_valid = 1'b0;
      issue_valid = v;
      issue_op = op;
      record_bit = rec;
      dest_reg = d;
      src_reg_s = s;
      src_reg_b = b;
      unsigned_imm = i;
      fixed_point_exception_reg = rnd();
   endtask
   task automatic close_out();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         close_out();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (16) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_n = 1'b1;
      for (int k = 0; k < 32; k++) begin
         @(negedge clk_sys);
         gpr[k] = (k == 1) ? 32'h0000_0080 : (k == 2) ? 32'h0000_8000 : rnd();
         load_valid = 1'b1;
         load_index = 5'(k);
         load_data = gpr[k];
      end
      // Every code with both record settings, back to back, sign bits set for the extends.
      for (int k = 0; k < 32; k++) step(1'b1, op_t'(k / 2), k[0], 5'(k) | 5'h10, 5'(k % 4), 5'(k + 7), 16'(rnd()));
      step(1'b1, op_xor, 1'b1, 5'h04, 5'h05, 5'h05, 16'h0000);
      repeat (300) begin
         r = rnd();
         step(r[0] | r[1], op_t'(r[5:2]), r[6], r[11:7], r[16:12], r[21:17], r[31:16]);
      end
      repeat (3) step(1'b0, op_and, 1'b0, 5'h00, 5'h00, 5'h00, 16'h0000);
      // Reset again in mid-run: outputs, registers and the condition field must all return to zero.
      @(negedge clk_sys);
      rst_n = 1'b0;
      @(negedge clk_sys);
      chk("retire_result_q", 32'h0000_0000, retire_result_q);
      rst_n = 1'b1;
      gpr = '{default: 32'h0000_0000};
      p1 = '0;
      p2 = '0;
      cond_exp = 4'h0;
      repeat (40) begin
         r = rnd();
         step(1'b1, op_t'(r[5:2]), r[6], r[11:7], r[16:12], r[21:17], r[31:16]);
      end
      repeat (3) step(1'b0, op_and, 1'b0, 5'h00, 5'h00, 5'h00, 16'h0000);
      close_out();
   end
endmodule
`default_nettype wire
